// file: nbu_pkg.sv
// package of constants and register map for the nine-bit serial port
// What this block does
// - frame: start, eight data bits LSB first, ninth bit, stop; eleven bit times
// - transmitted ninth bit is the software-written tx_ninth_bit control
// - receiver captures ninth bit and ignores the stop bit level
// - writing a byte to the data buffer starts a transmit frame
// - tx complete flag sets when the stop-bit time begins
// - no reception starts while the receive enable control is 0
// - accepted frame loads buffer, ninth bit field, sets rx complete flag
// - rejected frame leaves buffer, ninth bit field and rx flag unchanged
// - serial interrupt, when enabled, raised when either complete flag sets
package nbu_pkg;
  localparam logic [11:0] NBU_CTRL_OFS = 12'h000;
  localparam logic [11:0] NBU_DATA_OFS = 12'h004;
  localparam logic [11:0] NBU_BAUD_OFS = 12'h008;
  // control register field positions
  localparam int NBU_RI_BIT = 0;
  localparam int NBU_TI_BIT = 1;
  localparam int NBU_RB9_BIT = 2;
  localparam int NBU_TB9_BIT = 3;
  localparam int NBU_REN_BIT = 4;
  localparam int NBU_MCE_BIT = 5;
  localparam int NBU_IEN_BIT = 6;
  localparam int NBU_BUSY_BIT = 7;
  localparam logic [7:0] NBU_CTRL_RST = 8'h00;
  localparam logic [15:0] NBU_BAUD_RST = 16'h0056; // slow 348-cycle bit time out of reset
  localparam int NBU_OVS = 4; // ticks per bit, receive samples mid-bit
  localparam int NBU_FRAME_BITS = 11;
  typedef enum logic [1:0] {
    NBU_IDLE = 2'b00,
    NBU_START = 2'b01,
    NBU_SHIFT = 2'b11,
    NBU_STOP = 2'b10
  } nbu_state_t;
endpackage

// file: nbu_tick.sv
// baud tick divider producing one-cycle enable pulses
`timescale 1ns/1ps
module nbu_tick (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] div,
  output logic tick
);
  logic [15:0] cnt_r;
  // counts div+1 cycles per tick, restarted by reset only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// file: nbu_uart.sv
// nine-bit serial port with ahb-lite register slave
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module nbu_uart (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  output logic serial_irq
);
  import nbu_pkg::*;

  // bus address phase capture
  logic wr_pend_r, rd_pend_r;
  logic [11:0] addr_r;
  logic [7:0] ctl_r; // bit order per package, flags kept separately
  logic [15:0] baud_r;
  logic [7:0] serial_data_buffer_r;
  logic tx_complete_flag_r, rx_complete_flag_r, rx_ninth_bit_r;
  logic tx_start_r;
  logic tx_busy_r;
  logic tick;
  wire logic tx_ninth_bit = ctl_r[NBU_TB9_BIT];
  wire logic rx_enable_ctl = ctl_r[NBU_REN_BIT];
  wire logic multiproc_check_enable = ctl_r[NBU_MCE_BIT];
  wire logic irq_en = ctl_r[NBU_IEN_BIT];

  nbu_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .div(baud_r),
    .tick(tick)
  );

  // ahb-lite: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      rd_pend_r <= hsel && htrans[1] && !hwrite;
      addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data is assembled at address phase so it stands from a flop
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr)
      NBU_CTRL_OFS: begin
        rd_nxt[7:0] = ctl_r;
        rd_nxt[NBU_RI_BIT] = rx_complete_flag_r;
        rd_nxt[NBU_TI_BIT] = tx_complete_flag_r;
        rd_nxt[NBU_RB9_BIT] = rx_ninth_bit_r;
        rd_nxt[NBU_BUSY_BIT] = tx_busy_r;
      end
      NBU_DATA_OFS: rd_nxt[7:0] = serial_data_buffer_r;
      NBU_BAUD_OFS: rd_nxt[15:0] = baud_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  wire logic wr_ctl = wr_pend_r && (addr_r == NBU_CTRL_OFS);
  wire logic wr_data = wr_pend_r && (addr_r == NBU_DATA_OFS);

  // control and baud registers; flag bits held elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= NBU_CTRL_RST;
      baud_r <= NBU_BAUD_RST;
    end else begin
      if (wr_ctl) begin
        ctl_r <= hwdata[7:0];
      end
      if (wr_pend_r && (addr_r == NBU_BAUD_OFS)) begin
        baud_r <= hwdata[15:0];
      end
    end
  end

  // ---- transmitter ----
  nbu_state_t tx_st_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic [2:0] tx_div_r;
  logic tx_set;
  logic tx_bt;
  assign tx_bt = tick && (tx_div_r == 3'(NBU_OVS - 1));

  // a write while busy is held until the line is idle
  // frames start on a tick only, else the start bit could lose a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_start_r <= 1'b0;
    end else if (wr_data) begin
      tx_start_r <= 1'b1;
    end else if (tx_st_r == NBU_IDLE && tick) begin
      tx_start_r <= 1'b0;
    end
  end

  logic [7:0] tx_byte_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_byte_r <= 8'h00;
    end else if (wr_data) begin
      tx_byte_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_r <= NBU_IDLE;
      tx_sh_r <= 9'h1FF;
      tx_bit_r <= 4'h0;
      tx_div_r <= 3'h0;
      txd <= 1'b1;
      tx_busy_r <= 1'b0;
      tx_set <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (tick) begin
        tx_div_r <= (tx_div_r == 3'(NBU_OVS - 1)) ? 3'h0 : tx_div_r + 3'h1;
      end
      case (tx_st_r)
        NBU_IDLE: begin
          txd <= 1'b1;
          tx_busy_r <= 1'b0;
          if (tx_start_r && !wr_data && tick) begin
            tx_sh_r <= {tx_ninth_bit, tx_byte_r};
            tx_st_r <= NBU_START;
            tx_div_r <= 3'h0;
            tx_busy_r <= 1'b1;
            txd <= 1'b0;
          end
        end
        NBU_START: if (tx_bt) begin
          txd <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[8:1]};
          tx_bit_r <= 4'h0;
          tx_st_r <= NBU_SHIFT;
        end
        NBU_SHIFT: if (tx_bt) begin
          if (tx_bit_r == 4'h8) begin
            txd <= 1'b1;
            tx_set <= 1'b1;
            tx_st_r <= NBU_STOP;
          end else begin
            txd <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[8:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
          end
        end
        NBU_STOP: if (tx_bt) begin
          tx_st_r <= NBU_IDLE;
        end
        default: tx_st_r <= NBU_IDLE;
      endcase
    end
  end

  // ---- receiver, input through three flops ----
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_lvl_r <= rx_s3_r;
      end
    end
  end

  nbu_state_t rx_st_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_bit_r;
  logic [2:0] rx_div_r;
  logic rx_done;
  wire logic rx_ok = !rx_complete_flag_r && (!multiproc_check_enable || rx_sh_r[8]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r <= NBU_IDLE;
      rx_sh_r <= 9'h000;
      rx_bit_r <= 4'h0;
      rx_div_r <= 3'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick && rx_st_r != NBU_IDLE) begin
        rx_div_r <= rx_div_r + 3'h1;
      end
      case (rx_st_r)
        NBU_IDLE: if (rx_enable_ctl && !rx_lvl_r) begin
          rx_st_r <= NBU_START;
          rx_div_r <= 3'h0;
        end
        NBU_START: if (tick && rx_div_r == 3'(NBU_OVS / 2 - 1)) begin
          rx_div_r <= 3'h0;
          rx_bit_r <= 4'h0;
          // a start that is high at mid-bit was a glitch
          rx_st_r <= rx_lvl_r ? NBU_IDLE : NBU_SHIFT;
        end
        NBU_SHIFT: if (tick && rx_div_r == 3'(NBU_OVS - 1)) begin
          rx_div_r <= 3'h0;
          rx_sh_r <= {rx_lvl_r, rx_sh_r[8:1]};
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == 4'h8) begin
            rx_st_r <= NBU_STOP;
          end
        end
        NBU_STOP: if (tick && rx_div_r == 3'(NBU_OVS - 1)) begin
          rx_done <= 1'b1;
          rx_st_r <= NBU_IDLE;
        end
        default: rx_st_r <= NBU_IDLE;
      endcase
    end
  end

  // completion flags: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_complete_flag_r <= 1'b0;
      rx_complete_flag_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      serial_data_buffer_r <= 8'h00;
    end else begin
      if (tx_set) begin
        tx_complete_flag_r <= 1'b1;
      end else if (wr_ctl && !hwdata[NBU_TI_BIT]) begin
        tx_complete_flag_r <= 1'b0;
      end
      if (rx_done && rx_ok) begin
        serial_data_buffer_r <= rx_sh_r[7:0];
        rx_ninth_bit_r <= rx_sh_r[8];
        rx_complete_flag_r <= 1'b1;
      end else if (wr_ctl && !hwdata[NBU_RI_BIT]) begin
        rx_complete_flag_r <= 1'b0;
      end
    end
  end

  // interrupt level follows the flags while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= irq_en && (tx_complete_flag_r || rx_complete_flag_r);
    end
  end
endmodule

// file: nbu_uart_sva.sv
// port checker for the nine-bit serial port
`timescale 1ns/1ps
module nbu_uart_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd,
  input wire logic serial_irq
);
  logic [3:0] wr_age_r;
  // cycles since last register write, saturating so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_age_r <= 4'hF;
    else if (hsel && htrans[1] && hwrite) wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hF) wr_age_r <= wr_age_r + 4'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_idle; $rose(hresetn) |-> txd && !serial_irq; endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
  // bit times of 8 cycles assume the bench divider of 1
  property p_bit; $changed(txd) |=> $stable(txd) [*7]; endproperty
  a_bit: assert property (p_bit) else $error("short bit on txd");
  property p_start; $fell(txd) |-> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("short low level");
  // flags only clear by software, so irq falls only after a write
  property p_irq_fall; $fell(serial_irq) |-> wr_age_r <= 4'h4; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_rd_hold; !$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
  property p_rd_unmap;
    $past(hsel && htrans[1] && !hwrite && haddr > 12'h008) |-> hrdata == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  c_tx: cover property ($fell(txd));
  c_irq: cover property ($rose(serial_irq));
  c_clr: cover property ($fell(serial_irq));
endmodule

bind nbu_uart nbu_uart_chk chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .txd(txd), .serial_irq(serial_irq)
);

// file: nbu_node.sv
// remote serial node model driving the device's receive line
`timescale 1ns/1ps
module nbu_node #(
  parameter int BIT_CYC = 8
) (
  input wire logic hclk,
  input wire logic go,
  input wire logic [8:0] frame,
  output logic rxd
);
  logic [10:0] bits;
  initial rxd = 1'b1;
  // one frame per request, line rests high between frames
  always @(posedge hclk) begin
    if (go) begin
      bits = {1'b1, frame, 1'b0};
      for (int i = 0; i < 11; i++) begin
        rxd <= bits[i];
        repeat (BIT_CYC) @(posedge hclk);
      end
    end
  end
endmodule

// file: nbu_uart_tb.sv
// self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
module nbu_uart_tb;
  import nbu_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, node_go = 0, rb9 = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, q, c;
  logic hreadyout, hresp, rxd, txd, serial_irq;
  logic [8:0] node_frame = 9'h000;
  logic [10:0] got;
  logic [7:0] bufv = 8'h00;
  // rows: accept, check enable, ninth bit, byte
  logic [10:0] rows [4] = '{11'h5A5, 11'h23C, 11'h7C3, 11'h400};
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #50 hclk = ~hclk;
  nbu_uart dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .serial_irq(serial_irq));
  nbu_node #(.BIT_CYC(8)) node_u (.hclk(hclk), .go(node_go), .frame(node_frame), .rxd(rxd));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one single transfer, entered just after a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    q = hrdata;
  endtask
  task send(input logic [8:0] f);
    node_frame <= f; node_go <= 1;
    @(posedge hclk);
    node_go <= 0;
    repeat (100) @(posedge hclk);
  endtask
  // samples txd mid-bit, leaves at middle of the stop bit
  task txcap;
    while (txd) @(posedge hclk);
    repeat (4) @(posedge hclk);
    got[0] = txd;
    for (int i = 1; i < 11; i++) begin
      repeat (8) @(posedge hclk);
      got[i] = txd;
    end
  endtask
  // hang guard well above the expected run of some 1150 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    xfer(0, NBU_CTRL_OFS, 0); chk("ctrl reset", {24'h0, NBU_CTRL_RST}, q);
    xfer(0, NBU_BAUD_OFS, 0); chk("baud reset", {16'h0, NBU_BAUD_RST}, q);
    xfer(0, 12'h00C, 0); chk("unmapped", 32'h0, q);
    xfer(1, NBU_BAUD_OFS, 32'h1);
    send(9'h155); xfer(0, NBU_CTRL_OFS, 0); chk("rx off", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      c = {25'h0, 1'b1, rows[i][9], 1'b1, rows[i][8], 3'h0};
      xfer(1, NBU_CTRL_OFS, c);
      xfer(1, NBU_DATA_OFS, {24'h0, rows[i][7:0]});
      txcap; chk("tx frame", {1'b1, rows[i][8:0], 1'b0}, 32'(got));
      chk("irq at stop", 32'h1, 32'(serial_irq));
      xfer(0, NBU_CTRL_OFS, 0);
      chk("tx flag at stop", 32'h1, 32'(q[NBU_TI_BIT]));
      chk("tx busy in stop", 32'h1, 32'(q[NBU_BUSY_BIT]));
      xfer(1, NBU_CTRL_OFS, c);
      repeat (2) @(posedge hclk);
      chk("irq cleared", 32'h0, 32'(serial_irq));
      send(rows[i][8:0]);
      if (rows[i][10]) begin
        rb9 = rows[i][8];
        bufv = rows[i][7:0];
      end
      xfer(0, NBU_CTRL_OFS, 0); chk("rx flag", 32'(rows[i][10]), 32'(q[NBU_RI_BIT]));
      chk("rx ninth", 32'(rb9), 32'(q[NBU_RB9_BIT]));
      xfer(0, NBU_DATA_OFS, 0); chk("rx buffer", {24'h0, bufv}, q);
      xfer(1, NBU_CTRL_OFS, c);
    end
    // second frame while the flag is still set must be dropped
    send(9'h111); send(9'h022);
    xfer(0, NBU_DATA_OFS, 0); chk("rx kept", 32'h11, q);
    xfer(0, NBU_CTRL_OFS, 0); chk("rx ninth kept", 32'h1, 32'(q[NBU_RB9_BIT]));
    // reset in mid-run, with the rx flag and irq still up
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    chk("irq in reset", 32'h0, 32'(serial_irq));
    chk("txd in reset", 32'h1, 32'(txd));
    hresetn <= 1;
    @(posedge hclk);
    xfer(0, NBU_CTRL_OFS, 0);
    chk("ctrl after reset", {24'h0, NBU_CTRL_RST}, q);
    report_and_stop;
  end
endmodule
